//--- scp_pkg.sv
// constants shared by both ends of the three-wire control port
package scp_pkg;
    // clock and link timing
    localparam int CLK_MHZ       = 100;
    localparam int SCK_HALF_NS   = 80;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_TYP_US    = 4600;
    localparam int POR_MAX_US    = 9000;
    localparam int POR_CYC       = POR_MAX_US * CLK_MHZ;

    // framing
    localparam int ADDR_W        = 7;
    localparam int OCT_W         = 8;
    localparam int NREG          = 23;
    localparam logic RW_READ     = 1'b1;
    localparam logic RW_WRITE    = 1'b0;
    localparam int LOAD_EN_REG   = 0;
    localparam int LOAD_EN_BIT   = 0;

    // divider registers
    localparam int SWALLOW_COUNT_SET0    = 'h0a;
    localparam int MAIN_COUNT_SET0_HIGH  = 'h0b;
    localparam int MAIN_COUNT_SET0_LOW   = 'h0c;
    localparam int REF_COUNT_SET0_HIGH   = 'h0d;
    localparam int REF_COUNT_SET0_LOW    = 'h0e;
    localparam int SWALLOW_COUNT_SET1    = 'h0f;
    localparam int MAIN_COUNT_SET1_HIGH  = 'h10;
    localparam int MAIN_COUNT_SET1_LOW   = 'h11;
    localparam int REF_COUNT_SET1_HIGH   = 'h12;
    localparam int REF_COUNT_SET1_LOW    = 'h13;
    localparam int SWALLOW_W     = 6;
    localparam int MAIN_W        = 12;
    localparam int REF_W         = 12;
    localparam logic [4:0] PRE_LO = 5'h10;
    localparam logic [4:0] PRE_HI = 5'h11;

    // host controller registers on the axi4-lite side
    localparam logic [3:0] HOST_CMD_OFS  = 4'h0;
    localparam logic [3:0] HOST_STAT_OFS = 4'h4;
    localparam int CMD_ADDR_LSB  = 0;
    localparam int CMD_RW_BIT    = 7;
    localparam int CMD_DATA_LSB  = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_POR_BIT  = 1;
    localparam int STAT_DATA_LSB = 8;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- scp_if.sv
// three-wire link between host and device; resolves the shared data wire
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
    logic cs;
    logic sclk;
    logic io_host_o;
    logic io_host_oe;
    logic io_dev_o;
    logic io_dev_oe;
    logic io;

    // weak pull-up when nobody drives
    assign io = io_dev_oe ? io_dev_o : (io_host_oe ? io_host_o : 1'b1);

    modport dev  (input cs, input sclk, input io, output io_dev_o, output io_dev_oe);
    modport host (output cs, output sclk, output io_host_o, output io_host_oe, input io);
endinterface
`default_nettype wire

//--- scp_dev.sv
// device end: serial register port, register file and frequency dividers
`timescale 1ns/1ps
`default_nettype none
module scp_dev
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // serial link
    scp_if.dev        bus,
    // synthesizer side
    input  wire logic rf_tick,
    input  wire logic xco_tick,
    input  wire logic mod_select_upper,
    input  wire logic mod_select_lower,
    input  wire logic rx_mode,
    input  wire logic tx_data,
    output var  logic load_pulse,
    output var  logic fb_pulse,
    output var  logic ref_pulse,
    output var  logic set_sel
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ADDR = 4'b0010,
        S_WR   = 4'b0100,
        S_RD   = 4'b1000
    } scp_dst_e;

    typedef struct packed {
        logic [2:0]                  cs_s;
        logic [2:0]                  sck_s;
        logic [1:0]                  io_s;
        scp_dst_e                    st;
        logic [2:0]                  cnt;
        logic [OCT_W-1:0]            sh;
        logic [ADDR_W:0]             ptr;
        logic                        wr_seen;
        logic [NREG-1:0][OCT_W-1:0]  shadow;
        logic [NREG-1:0][OCT_W-1:0]  active;
        logic                        io_o;
        logic                        io_oe;
        logic                        load_p;
        logic [4:0]                  pre;
        logic [MAIN_W-1:0]           mcnt;
        logic [SWALLOW_W-1:0]        acnt;
        logic [REF_W-1:0]            rcnt;
        logic                        set;
        logic                        fb_p;
        logic                        ref_p;
    } scp_dev_s;

    scp_dev_s r;
    scp_dev_s n;

    logic                 rise;
    logic                 fall;
    logic                 cs_hi;
    logic                 cs_rise;
    logic                 cs_fall;
    logic                 io_in;
    logic [OCT_W-1:0]     oct;
    logic [OCT_W-1:0]     rd_oct;
    logic [SWALLOW_W-1:0] a_v;
    logic [MAIN_W-1:0]    n_v;
    logic [REF_W-1:0]     m_v;
    logic [4:0]           modulus;
    logic                 sel_now;

    always_comb begin
        n        = r;
        n.load_p = 1'b0;
        n.fb_p   = 1'b0;
        n.ref_p  = 1'b0;

        // two-flop synchronisers, third stage only for edge finding
        n.cs_s  = {r.cs_s[1:0], bus.cs};
        n.sck_s = {r.sck_s[1:0], bus.sclk};
        n.io_s  = {r.io_s[0], bus.io};
        rise    = r.sck_s[1] & ~r.sck_s[2];
        fall    = ~r.sck_s[1] & r.sck_s[2];
        cs_hi   = r.cs_s[1];
        cs_rise = r.cs_s[1] & ~r.cs_s[2];
        cs_fall = ~r.cs_s[1] & r.cs_s[2];
        io_in   = r.io_s[1];
        oct     = {r.sh[OCT_W-2:0], io_in};
        rd_oct  = (r.ptr < (ADDR_W+1)'(NREG)) ? r.shadow[r.ptr] : 8'h00;

        case (r.st)
            S_IDLE: begin
                if (cs_rise) begin
                    n.st      = S_ADDR;
                    n.cnt     = 3'h0;
                    n.wr_seen = 1'b0;
                end
            end
            S_ADDR: begin
                if (fall) begin
                    n.sh  = oct;
                    n.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        // address then rw bit make the first octet
                        n.ptr = {1'b0, oct[OCT_W-1:1]};
                        n.cnt = 3'h0;
                        n.st  = (oct[0] == RW_READ) ? S_RD : S_WR;
                    end
                end
            end
            S_WR: begin
                if (fall) begin
                    n.sh  = oct;
                    n.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        if (r.ptr < (ADDR_W+1)'(NREG)) begin
                            n.shadow[r.ptr] = oct;
                        end
                        n.wr_seen = 1'b1;
                        n.ptr     = r.ptr + 8'h01;
                    end
                end
            end
            S_RD: begin
                if (rise) begin
                    n.io_oe = 1'b1;
                    n.cnt   = r.cnt + 3'h1;
                    if (r.cnt == 3'h0) begin
                        // fetch without touching the stored value
                        n.io_o = rd_oct[OCT_W-1];
                        n.sh   = {rd_oct[OCT_W-2:0], 1'b0};
                        n.ptr  = r.ptr + 8'h01;
                    end else begin
                        n.io_o = r.sh[OCT_W-1];
                        n.sh   = {r.sh[OCT_W-2:0], 1'b0};
                    end
                end
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase

        // select low ends any frame
        if (!cs_hi && r.st != S_IDLE) begin
            n.st    = S_IDLE;
            n.io_oe = 1'b0;
        end
        if (cs_fall && r.st == S_WR && r.wr_seen) begin
            if (r.shadow[LOAD_EN_REG][LOAD_EN_BIT]) begin
                n.active = r.shadow;
                n.load_p = 1'b1;
            end
        end

        // divider values of the selected set
        a_v = r.set ? r.active[SWALLOW_COUNT_SET1][SWALLOW_W-1:0]
                    : r.active[SWALLOW_COUNT_SET0][SWALLOW_W-1:0];
        n_v = r.set ? {r.active[MAIN_COUNT_SET1_HIGH][3:0], r.active[MAIN_COUNT_SET1_LOW]}
                    : {r.active[MAIN_COUNT_SET0_HIGH][3:0], r.active[MAIN_COUNT_SET0_LOW]};
        m_v = r.set ? {r.active[REF_COUNT_SET1_HIGH][3:0], r.active[REF_COUNT_SET1_LOW]}
                    : {r.active[REF_COUNT_SET0_HIGH][3:0], r.active[REF_COUNT_SET0_LOW]};

        // set 1 only under divider modulation while transmitting
        sel_now = mod_select_upper & ~mod_select_lower & ~rx_mode & tx_data;

        // dual-modulus prescaler and main/swallow counters
        modulus = (r.acnt != '0) ? PRE_LO : PRE_HI;
        if (rf_tick) begin
            if (r.pre >= modulus - 5'h1) begin
                n.pre = 5'h0;
                if (r.mcnt <= 12'h001) begin
                    n.mcnt = n_v;
                    n.acnt = a_v;
                    n.fb_p = 1'b1;
                    n.set  = sel_now;
                end else begin
                    n.mcnt = r.mcnt - 12'h001;
                    if (r.acnt != '0) begin
                        n.acnt = r.acnt - 6'h01;
                    end
                end
            end else begin
                n.pre = r.pre + 5'h1;
            end
        end

        // reference divider
        if (xco_tick) begin
            if (r.rcnt + 12'h001 >= m_v) begin
                n.rcnt  = 12'h000;
                n.ref_p = 1'b1;
            end else begin
                n.rcnt = r.rcnt + 12'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r    <= '0;
            r.st <= S_IDLE;
        end else begin
            r <= n;
        end
    end

    assign bus.io_dev_o  = r.io_o;
    assign bus.io_dev_oe = r.io_oe;
    assign load_pulse    = r.load_p;
    assign fb_pulse      = r.fb_p;
    assign ref_pulse     = r.ref_p;
    assign set_sel       = r.set;
endmodule
`default_nettype wire

//--- scp_host.sv
// host end: axi4-lite command registers driving the three-wire link
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module scp_host
    import scp_pkg::*;
#(
    parameter int POR_WAIT = POR_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial link
    scp_if.host              bus
);
    typedef enum logic [4:0] {
        H_IDLE  = 5'b00001,
        H_SETUP = 5'b00010,
        H_HI    = 5'b00100,
        H_LO    = 5'b01000,
        H_END   = 5'b10000
    } scp_hst_e;

    typedef struct packed {
        scp_hst_e    st;
        logic [23:0] por;
        logic        por_done;
        logic [3:0]  hc;
        logic [3:0]  bitn;
        logic [15:0] sh;
        logic        rw;
        logic [7:0]  rx;
        logic [15:0] cmd;
        logic [7:0]  rdata_l;
        logic [1:0]  io_s;
        logic        cs;
        logic        sclk;
        logic        io_o;
        logic        io_oe;
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  aw_addr;
        logic [15:0] wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scp_host_s;

    scp_host_s r;
    scp_host_s n;
    logic      half;
    logic      io_in;
    logic      busy;

    always_comb begin
        n      = r;
        n.io_s = {r.io_s[0], bus.io};
        io_in  = r.io_s[1];
        half   = (r.hc == 4'(SCK_HALF_CYC - 1));
        n.hc   = half ? 4'h0 : r.hc + 4'h1;
        busy   = (r.st != H_IDLE);

        // hold off access until power-on reset has surely finished
        if (!r.por_done) begin
            n.por = r.por + 24'h1;
            if (r.por >= 24'(POR_WAIT - 1)) begin
                n.por_done = 1'b1;
            end
        end

        // write channel
        if (s_axi_awvalid && r.awready) begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata[15:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = (r.aw_addr == HOST_CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
            // a command while busy or before power-on is dropped
            if (r.aw_addr == HOST_CMD_OFS && !busy && r.por_done) begin
                n.cmd  = r.wdata;
                // address msb first, rw bit closes the first octet
                n.sh   = {r.wdata[CMD_RW_BIT-1:CMD_ADDR_LSB], r.wdata[CMD_RW_BIT],
                          r.wdata[15:CMD_DATA_LSB]};
                n.rw   = r.wdata[CMD_RW_BIT];
                n.bitn = 4'h0;
                n.hc   = 4'h0;
                n.cs   = 1'b1;
                n.st   = H_SETUP;
            end
        end
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready  = ~n.w_got & ~n.bvalid;

        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0;
            case (s_axi_araddr)
                HOST_CMD_OFS:  n.rdata[15:0] = r.cmd;
                HOST_STAT_OFS: n.rdata = {16'h0, r.rdata_l, 6'h0, r.por_done, busy};
                default:       n.rresp = RESP_SLVERR;
            endcase
        end
        n.arready = ~n.rvalid;

        // link engine: host makes every clock edge
        case (r.st)
            H_IDLE: begin
                n.sclk  = 1'b0;
                n.io_oe = 1'b1;
            end
            H_SETUP, H_LO: begin
                if (half) begin
                    if (r.st == H_LO && r.bitn == 4'hf) begin
                        n.st = H_END;
                    end else begin
                        n.bitn = (r.st == H_LO) ? r.bitn + 4'h1 : r.bitn;
                        n.st   = H_HI;
                        n.sclk = 1'b1;
                        if (r.rw == RW_READ && n.bitn >= 4'h8) begin
                            n.io_oe = 1'b0;
                        end else begin
                            n.io_o = r.sh[15];
                            n.sh   = {r.sh[14:0], 1'b0};
                        end
                    end
                end
            end
            H_HI: begin
                if (half) begin
                    n.sclk = 1'b0;
                    n.st   = H_LO;
                    if (r.rw == RW_READ && r.bitn >= 4'h8) begin
                        n.rx = {r.rx[6:0], io_in};
                    end
                end
            end
            H_END: begin
                if (half) begin
                    if (r.cs) begin
                        n.cs = 1'b0;
                        if (r.rw == RW_READ) begin
                            n.rdata_l = r.rx;
                        end
                    end else begin
                        // device sees select low only after its synchroniser
                        n.io_oe = 1'b1;
                        n.st    = H_IDLE;
                    end
                end
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r       <= '0;
            r.st    <= H_IDLE;
            r.io_oe <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready  = r.awready;
    assign s_axi_wready   = r.wready;
    assign s_axi_bresp    = r.bresp;
    assign s_axi_bvalid   = r.bvalid;
    assign s_axi_arready  = r.arready;
    assign s_axi_rdata    = r.rdata;
    assign s_axi_rresp    = r.rresp;
    assign s_axi_rvalid   = r.rvalid;
    assign bus.cs         = r.cs;
    assign bus.sclk       = r.sclk;
    assign bus.io_host_o  = r.io_o;
    assign bus.io_host_oe = r.io_oe;
endmodule
`default_nettype wire

//--- scp_props.sv
// wire-level assertions for the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module scp_props
    import scp_pkg::*;
#(
    parameter int POR_WAIT = POR_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link wires
    input wire logic cs,
    input wire logic sclk,
    input wire logic io_host_o,
    input wire logic io_host_oe,
    input wire logic io_dev_o,
    input wire logic io_dev_oe,
    input wire logic io
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // falls counted in the current frame, rw bit caught at the eighth fall
    logic [4:0] fall_r;
    logic       rw_r;
    int         por_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fall_r <= 5'h0;
            rw_r   <= 1'b0;
            por_r  <= 0;
        end else begin
            if (por_r < POR_WAIT) por_r <= por_r + 1;
            if ($rose(cs)) fall_r <= 5'h0;
            else if (cs && $fell(sclk)) fall_r <= fall_r + 5'h1;
            if (cs && $fell(sclk) && fall_r == 5'h7) rw_r <= io;
        end
    end

    por_quiet_a: assert property (por_r < POR_WAIT |-> !cs)
        else $error("select raised inside power-on wait");
    sclk_idle_a: assert property (!cs |-> !sclk)
        else $error("serial clock active outside a frame");
    high_len_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase not eight cycles");
    wr_stable_a: assert property ($fell(sclk) && io_host_oe |-> $stable(io_host_o))
        else $error("host data moved at a falling edge");
    no_fight_a: assert property (io_dev_oe |-> !io_host_oe)
        else $error("both ends drive the data line");
    dev_start_a: assert property ($rose(io_dev_oe) |-> cs && sclk && rw_r == RW_READ
        && fall_r == 5'h8)
        else $error("device drive began outside the first read rise");
    dev_change_a: assert property (cs && io_dev_oe && $changed(io_dev_o) |-> sclk)
        else $error("device data moved while clock low");
    host_off_a: assert property (cs && $rose(sclk) && fall_r == 5'h8 && rw_r == RW_READ
        |=> !io_host_oe)
        else $error("host still drives in read phase");
    dev_release_a: assert property ($fell(cs) |-> ##[0:4] !io_dev_oe)
        else $error("device kept the line after select fall");
    host_back_a: assert property ($fell(cs) |-> ##8 io_host_oe)
        else $error("host not driving after frame");
    frame_len_a: assert property ($fell(cs) |-> fall_r == 5'h10)
        else $error("frame not sixteen bits");

    cover property ($rose(io_dev_oe));
    cover property ($fell(cs) && rw_r == RW_WRITE);
    cover property ($fell(cs) && rw_r == RW_READ);
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for both ends of the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scp_pkg::*;
    localparam int PW  = 20;
    localparam int A_V = 'h3f;
    localparam int N_V = 'h105;
    localparam int M_V = 'h103;
    // address, value written, value read back
    localparam logic [22:0] ROWS [9] = '{{7'h00, 8'h01, 8'h01}, {7'h0a, 8'h3f, 8'h3f},
        {7'h0b, 8'h01, 8'h01}, {7'h0c, 8'h02, 8'h02}, {7'h0d, 8'h01, 8'h01},
        {7'h0e, 8'h03, 8'h03}, {7'h0f, 8'h15, 8'h15}, {7'h16, 8'ha5, 8'ha5},
        {7'h17, 8'h5a, 8'h00}};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        rf_tick = 1'b0, xco_tick = 1'b0, rx_mode = 1'b0, tx_data = 1'b0;
    logic        mod_select_upper = 1'b0, mod_select_lower = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        load_pulse, fb_pulse, ref_pulse, set_sel;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, s;
    logic [7:0]  q;
    int          error_cnt = 0, cmp_count = 0, load_cnt = 0, frames = 0, g, lc;

    scp_if bus_if ();
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (load_pulse === 1'b1) load_cnt <= load_cnt + 1;
    always @(posedge bus_if.cs) frames <= frames + 1;

    scp_host #(.POR_WAIT(PW)) scp_host_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus_if));
    scp_dev scp_dev_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .rf_tick(rf_tick),
        .xco_tick(xco_tick), .mod_select_upper(mod_select_upper),
        .mod_select_lower(mod_select_lower), .rx_mode(rx_mode), .tx_data(tx_data),
        .load_pulse(load_pulse), .fb_pulse(fb_pulse), .ref_pulse(ref_pulse),
        .set_sel(set_sel));
    scp_props #(.POR_WAIT(PW)) scp_props_inst (.aclk(aclk), .aresetn(aresetn),
        .cs(bus_if.cs), .sclk(bus_if.sclk), .io_host_o(bus_if.io_host_o),
        .io_host_oe(bus_if.io_host_oe), .io_dev_o(bus_if.io_dev_o),
        .io_dev_oe(bus_if.io_dev_oe), .io(bus_if.io));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic timeout_hit();
        $display("ERROR %0t: wait ran out", $time);
        error_cnt++;
        conclude();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 100) timeout_hit();
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 100) timeout_hit();
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? bus_if.cs : set_sel;
    endfunction
    task automatic wait_for(input int w, input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge aclk);
            if (pick(w) === v) break;
        end
        if (n == lim) timeout_hit();
    endtask
    // one whole frame through the host registers, result from status
    task automatic link(input logic [6:0] a, input logic rw, input logic [7:0] d,
                        output logic [7:0] rd);
        axi_wr(HOST_CMD_OFS, {16'h0, d, rw, a}, r);
        wait_for(0, 1'b1, 50);
        wait_for(0, 1'b0, 600);
        repeat (8) @(posedge aclk);
        axi_rd(HOST_STAT_OFS, s, r);
        rd = s[15:8];
    endtask
    // cycles between two pulses of the feedback or reference divider
    task automatic gap(input logic sel, output int n2);
        int n;
        n2 = 0;
        for (n = 0; n < 20000; n++) begin
            @(posedge aclk);
            if ((sel ? ref_pulse : fb_pulse) === 1'b1) begin
                if (n2 > 0) break;
                n2 = 1;
            end else if (n2 > 0) n2++;
        end
        if (n == 20000) timeout_hit();
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(HOST_STAT_OFS, s, r);
        check(32'(s[1:0]), 32'h0);
        axi_wr(HOST_CMD_OFS, 32'h0000_0100, r);
        repeat (PW + 20) @(posedge aclk);
        check(frames, 32'h0);
        axi_rd(HOST_STAT_OFS, s, r);
        check(32'(s[STAT_POR_BIT]), 32'h1);
        axi_wr(4'h8, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_rd(4'h8, s, r);
        check({s[29:0], r}, {30'h0, RESP_SLVERR});
        $display("power-on and map test done");
        rf_tick <= 1'b1;
        xco_tick <= 1'b1;
        for (int i = 0; i < NREG; i++) begin
            link(7'(i), RW_WRITE, 8'h00, q);
        end
        for (int i = 0; i < 9; i++) begin
            link(ROWS[i][22:16], RW_WRITE, ROWS[i][15:8], q);
            link(ROWS[i][22:16], RW_READ, 8'h00, q);
            check(32'(q), 32'(ROWS[i][7:0]));
            link(ROWS[i][22:16], RW_READ, 8'h00, q);
            check(32'(q), 32'(ROWS[i][7:0]));
        end
        $display("register table done");
        lc = load_cnt;
        link(7'h00, RW_WRITE, 8'h00, q);
        link(7'h0c, RW_WRITE, 8'h05, q);
        check(load_cnt - lc, 32'h0);
        link(7'h00, RW_WRITE, 8'h01, q);
        check(load_cnt - lc, 32'h1);
        $display("load test done");
        gap(1'b0, g);
        gap(1'b0, g);
        check(g, 16 * A_V + 17 * (N_V - A_V));
        gap(1'b1, g);
        gap(1'b1, g);
        check(g, M_V);
        mod_select_upper <= 1'b1;
        tx_data <= 1'b1;
        wait_for(1, 1'b1, 20000);
        check(32'(set_sel), 32'h1);
        rx_mode <= 1'b1;
        wait_for(1, 1'b0, 20000);
        check(32'(set_sel), 32'h0);
        rx_mode <= 1'b0;
        mod_select_lower <= 1'b1;
        gap(1'b0, g);
        check(32'(set_sel), 32'h0);
        $display("divider test done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (PW + 5) @(posedge aclk);
        link(7'h0a, RW_READ, 8'h00, q);
        check(32'(q), 32'h0);
        $display("second reset test done");
        conclude();
    end
endmodule
`default_nettype wire
